// ==== src/dhc_defines.svh ====
// Purpose: addresses, field positions and reset values of the debug hold control block
// Assumes: full 32-bit byte addresses on the register bus
// Notes:   included by bare name
`ifndef DHC_DEFINES_SVH
`define DHC_DEFINES_SVH

`define DHC_BASE_ADDR     32'he004_2000
`define DHC_ID_OFS        32'h0000_0000
`define DHC_CTL0_OFS      32'h0000_0004
`define DHC_CTL1_OFS      32'h0000_0008
`define DHC_PORT_CFG_OFS  32'h0000_000c
`define DHC_ROM_BASE      32'he00f_f000
`define DHC_ROM_WIN       6'h3f
`define DHC_RESET_VAL     32'h0000_0000

`define DHC_CTL0_MASK     32'h080b_9f07
`define DHC_CTL1_MASK     32'h0007_0400
`define DHC_PORT_CFG_MASK 32'h0000_0001

`define DHC_SLP_BIT       0
`define DHC_DSLP_BIT      1
`define DHC_STB_BIT       2
`define DHC_FWD_BIT       8
`define DHC_WWD_BIT       9
`define DHC_TMR0_BIT      10
`define DHC_TMR1_BIT      11
`define DHC_TMR2_BIT      12
`define DHC_TW0_BIT       15
`define DHC_TW1_BIT       16
`define DHC_TW2_BIT       17
`define DHC_TMR5_BIT      19
`define DHC_TMR13_BIT     27
`define DHC_RTC_BIT       10
`define DHC_TMR14_BIT     16
`define DHC_TMR15_BIT     17
`define DHC_TMR16_BIT     18
`define DHC_RELEASE_BIT   0

`define DHC_ROM_PID4_IDX  4'h4
`define DHC_ROM_PID0_IDX  4'h8
`define DHC_ROM_PID1_IDX  4'h9
`define DHC_ROM_PID2_IDX  4'ha
`define DHC_ROM_CID0_IDX  4'hc
`define DHC_ROM_CID1_IDX  4'hd
`define DHC_ROM_CID2_IDX  4'he
`define DHC_ROM_CID3_IDX  4'hf
`define DHC_ROM_CID0      8'h0d
`define DHC_ROM_CID1      8'h10
`define DHC_ROM_CID2      8'h05
`define DHC_ROM_CID3      8'hb1

`endif

// ==== src/dhc_pkg.sv ====
// Purpose: types of the debug hold control block
// Assumes: nothing
// Notes:   bus states are gray coded along idle, fetch, answer
package dhc_pkg;
	typedef enum logic [1:0] {
		DHC_ST_IDLE   = 2'b00,
		DHC_ST_FETCH  = 2'b01,
		DHC_ST_ANSWER = 2'b11
	} dhc_bus_e;
endpackage

// ==== src/dhc_rom.sv ====
// Purpose: identification table words behind the debug rom window
// Assumes: index is held stable for a cycle before the word is used
// Notes:   read data come from a register, one cycle after the index
`include "dhc_defines.svh"
module dhc_rom import dhc_pkg::*; #(
	parameter logic [6:0]  JEP_ID   = 7'h15,  // arbitrary value
	parameter logic [3:0]  JEP_CONT = 4'h2,   // arbitrary value
	parameter logic [11:0] PART_NUM = 12'h3c1, // arbitrary value
	parameter logic [3:0]  REV      = 4'h1    // arbitrary value
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  idx_i,
	output logic      [31:0] rd_o
);
	logic [31:0] rd_nxt;

	function automatic logic [31:0] rom_word(input logic [3:0] idx);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			`DHC_ROM_PID4_IDX: b = {4'h0, JEP_CONT};
			`DHC_ROM_PID0_IDX: b = PART_NUM[7:0];
			`DHC_ROM_PID1_IDX: b = {JEP_ID[3:0], PART_NUM[11:8]};
			`DHC_ROM_PID2_IDX: b = {REV, 1'b1, JEP_ID[6:4]}; // jedec code in use
			`DHC_ROM_CID0_IDX: b = `DHC_ROM_CID0;
			`DHC_ROM_CID1_IDX: b = `DHC_ROM_CID1;
			`DHC_ROM_CID2_IDX: b = `DHC_ROM_CID2;
			`DHC_ROM_CID3_IDX: b = `DHC_ROM_CID3;
			default:           b = 8'h00;
		endcase
		return {24'h00_0000, b};
	endfunction

	always_comb begin
		rd_nxt = rom_word(idx_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_o <= 32'h0000_0000;
		end else begin
			rd_o <= rd_nxt;
		end
	end
endmodule // dhc_rom

// ==== src/dhc_top.sv ====
// Purpose: debug hold control: id and freeze registers, halt freezes, low power clock keeps, pin release
// Assumes: classic wishbone slave, one clock, por_i is the power-on reset, rst_i the system reset
// Notes:   every access is answered two cycles after it is taken
// How it works
// - standby keep selects internal rc clock
// - leaving standby with keep requests system reset
// - deep-sleep keep selects internal rc clock
// - sleep keep leaves bus clock running
// - timer freeze bits hold counters while halted
// - two-wire freeze bits hold bus timeouts
// - rtc freeze bit stops rtc while halted
// - watchdog freeze bits stop watchdog clocks
// - bits change only by software; zero inert
// - control registers cleared by power reset only
// - identification register constant, writes ignored
// - id at base, control zero at four
// - two debug pins, released when unused
// - jedec identification readable from rom table
// - second control register holds rtc freeze
// - second control register holds timer14-16 freezes
`include "dhc_defines.svh"
module dhc_top import dhc_pkg::*; #(
	parameter logic [31:0] ID_VALUE = 32'h0000_5a01, // arbitrary value
	parameter logic [6:0]  JEP_ID   = 7'h15,         // arbitrary value
	parameter logic [3:0]  JEP_CONT = 4'h2,          // arbitrary value
	parameter logic [11:0] PART_NUM = 12'h3c1,       // arbitrary value
	parameter logic [3:0]  REV      = 4'h1           // arbitrary value
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic             ack_o,
	output logic             err_o,
	output logic      [31:0] dat_o,
	input  wire logic        core_halted_i,
	input  wire logic        sleep_i,
	input  wire logic        deepsleep_i,
	input  wire logic        standby_i,
	output logic             bus_clock_keep_o,
	output logic             internal_rc_8mhz_clock_sel_o,
	output logic             sysrst_req_o,
	output logic             tmr0_halt_freeze_o,
	output logic             tmr1_halt_freeze_o,
	output logic             tmr2_halt_freeze_o,
	output logic             tmr5_halt_freeze_o,
	output logic             tmr13_halt_freeze_o,
	output logic             tmr14_halt_freeze_o,
	output logic             tmr15_halt_freeze_o,
	output logic             tmr16_halt_freeze_o,
	output logic             twowire0_timeout_freeze_o,
	output logic             twowire1_timeout_freeze_o,
	output logic             twowire2_timeout_freeze_o,
	output logic             window_watchdog_freeze_o,
	output logic             free_watchdog_freeze_o,
	output logic             rtc_halt_freeze_o,
	input  wire logic        swclk_i,
	output logic             swclk_o,
	output logic             swclk_oe_o,
	input  wire logic        swdio_i,
	output logic             swdio_o,
	output logic             swdio_oe_o,
	output logic             dp_swclk_o,
	output logic             dp_swdio_o,
	input  wire logic        dp_swdio_out_i,
	input  wire logic        dp_swdio_oe_i,
	input  wire logic        gpio_swclk_out_i,
	input  wire logic        gpio_swclk_oe_i,
	input  wire logic        gpio_swdio_out_i,
	input  wire logic        gpio_swdio_oe_i
);
	dhc_bus_e    st_r, st_nxt;
	logic        ack_nxt, err_nxt;
	logic [31:0] dat_nxt;
	logic [31:0] ctl0_r, ctl0_nxt;
	logic [31:0] ctl1_r, ctl1_nxt;
	logic [31:0] cfg_r, cfg_nxt;
	logic [31:0] rom_rd;
	logic        rom_hit, reg_hit, wr_ok;
	logic        stb_prev_r, stb_prev_nxt;
	logic        keep_nxt, irc_nxt, rst_req_nxt;
	logic [13:0] frz_r, frz_nxt;
	logic        pins_owned;
	logic [5:0]  pin_nxt;

	function automatic logic at_reg(input logic [31:0] adr, input logic [31:0] ofs);
		return adr == (`DHC_BASE_ADDR + ofs);
	endfunction

	function automatic logic halt_freeze(input logic [31:0] ctl, input int pos, input logic halted);
		return ctl[pos] & halted;
	endfunction

	dhc_rom #(
		.JEP_ID   (JEP_ID),
		.JEP_CONT (JEP_CONT),
		.PART_NUM (PART_NUM),
		.REV      (REV)
	) u_rom (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.idx_i (adr_i[5:2]),
		.rd_o  (rom_rd)
	);

	// the rom only shows its last 16 words; the rest of the 4 kb window reads zero
	assign rom_hit = (adr_i[31:12] == 20'(`DHC_ROM_BASE >> 12));
	assign reg_hit = at_reg(adr_i, `DHC_ID_OFS) | at_reg(adr_i, `DHC_CTL0_OFS) |
	                 at_reg(adr_i, `DHC_CTL1_OFS) | at_reg(adr_i, `DHC_PORT_CFG_OFS);
	// partial lanes are refused rather than merged into a word
	assign wr_ok   = (st_r == DHC_ST_FETCH) && reg_hit && we_i && (sel_i == 4'hf);

	always_comb begin
		st_nxt  = st_r;
		ack_nxt = 1'b0;
		err_nxt = 1'b0;
		dat_nxt = dat_o;
		cfg_nxt = cfg_r;
		unique case (st_r)
			DHC_ST_IDLE: begin
				if (cyc_i && stb_i) begin
					st_nxt = DHC_ST_FETCH;
				end
			end
			DHC_ST_FETCH: begin
				st_nxt = DHC_ST_ANSWER;
				if (!(reg_hit || rom_hit) || sel_i != 4'hf) begin
					err_nxt = 1'b1;
					dat_nxt = 32'h0000_0000;
				end else begin
					ack_nxt = 1'b1;
					if (we_i) begin
						if (at_reg(adr_i, `DHC_PORT_CFG_OFS)) begin
							cfg_nxt = dat_i & `DHC_PORT_CFG_MASK;
						end
					end else if (rom_hit) begin
						dat_nxt = (adr_i[11:6] == `DHC_ROM_WIN) ? rom_rd : 32'h0000_0000;
					end else if (at_reg(adr_i, `DHC_ID_OFS)) begin
						dat_nxt = ID_VALUE;
					end else if (at_reg(adr_i, `DHC_CTL0_OFS)) begin
						dat_nxt = ctl0_r;
					end else if (at_reg(adr_i, `DHC_CTL1_OFS)) begin
						dat_nxt = ctl1_r;
					end else begin
						dat_nxt = cfg_r;
					end
				end
			end
			DHC_ST_ANSWER: begin
				st_nxt = DHC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r  <= DHC_ST_IDLE;
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			cfg_r <= `DHC_RESET_VAL;
		end else begin
			st_r  <= st_nxt;
			ack_o <= ack_nxt;
			err_o <= err_nxt;
			dat_o <= dat_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// control registers survive system reset so a debugger keeps its setup across it
	always_comb begin
		ctl0_nxt = ctl0_r;
		ctl1_nxt = ctl1_r;
		if (wr_ok && at_reg(adr_i, `DHC_CTL0_OFS)) begin
			ctl0_nxt = dat_i & `DHC_CTL0_MASK;
		end
		if (wr_ok && at_reg(adr_i, `DHC_CTL1_OFS)) begin
			ctl1_nxt = dat_i & `DHC_CTL1_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (por_i) begin
			ctl0_r <= `DHC_RESET_VAL;
			ctl1_r <= `DHC_RESET_VAL;
		end else begin
			ctl0_r <= ctl0_nxt;
			ctl1_r <= ctl1_nxt;
		end
	end

	always_comb begin
		stb_prev_nxt = standby_i;
		keep_nxt     = sleep_i & ctl0_r[`DHC_SLP_BIT];
		irc_nxt      = (standby_i & ctl0_r[`DHC_STB_BIT]) | (deepsleep_i & ctl0_r[`DHC_DSLP_BIT]);
		rst_req_nxt  = stb_prev_r & ~standby_i & ctl0_r[`DHC_STB_BIT];
		frz_nxt[0]   = halt_freeze(ctl0_r, `DHC_TMR0_BIT, core_halted_i);
		frz_nxt[1]   = halt_freeze(ctl0_r, `DHC_TMR1_BIT, core_halted_i);
		frz_nxt[2]   = halt_freeze(ctl0_r, `DHC_TMR2_BIT, core_halted_i);
		frz_nxt[3]   = halt_freeze(ctl0_r, `DHC_TMR5_BIT, core_halted_i);
		frz_nxt[4]   = halt_freeze(ctl0_r, `DHC_TMR13_BIT, core_halted_i);
		frz_nxt[5]   = halt_freeze(ctl1_r, `DHC_TMR14_BIT, core_halted_i);
		frz_nxt[6]   = halt_freeze(ctl1_r, `DHC_TMR15_BIT, core_halted_i);
		frz_nxt[7]   = halt_freeze(ctl1_r, `DHC_TMR16_BIT, core_halted_i);
		frz_nxt[8]   = halt_freeze(ctl0_r, `DHC_TW0_BIT, core_halted_i);
		frz_nxt[9]   = halt_freeze(ctl0_r, `DHC_TW1_BIT, core_halted_i);
		frz_nxt[10]  = halt_freeze(ctl0_r, `DHC_TW2_BIT, core_halted_i);
		frz_nxt[11]  = halt_freeze(ctl0_r, `DHC_WWD_BIT, core_halted_i);
		frz_nxt[12]  = halt_freeze(ctl0_r, `DHC_FWD_BIT, core_halted_i);
		frz_nxt[13]  = halt_freeze(ctl1_r, `DHC_RTC_BIT, core_halted_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stb_prev_r                   <= 1'b0;
			bus_clock_keep_o             <= 1'b0;
			internal_rc_8mhz_clock_sel_o <= 1'b0;
			sysrst_req_o                 <= 1'b0;
			frz_r                        <= 14'h0000;
		end else begin
			stb_prev_r                   <= stb_prev_nxt;
			bus_clock_keep_o             <= keep_nxt;
			internal_rc_8mhz_clock_sel_o <= irc_nxt;
			sysrst_req_o                 <= rst_req_nxt;
			frz_r                        <= frz_nxt;
		end
	end

	assign tmr0_halt_freeze_o        = frz_r[0];
	assign tmr1_halt_freeze_o        = frz_r[1];
	assign tmr2_halt_freeze_o        = frz_r[2];
	assign tmr5_halt_freeze_o        = frz_r[3];
	assign tmr13_halt_freeze_o       = frz_r[4];
	assign tmr14_halt_freeze_o       = frz_r[5];
	assign tmr15_halt_freeze_o       = frz_r[6];
	assign tmr16_halt_freeze_o       = frz_r[7];
	assign twowire0_timeout_freeze_o = frz_r[8];
	assign twowire1_timeout_freeze_o = frz_r[9];
	assign twowire2_timeout_freeze_o = frz_r[10];
	assign window_watchdog_freeze_o  = frz_r[11];
	assign free_watchdog_freeze_o    = frz_r[12];
	assign rtc_halt_freeze_o         = frz_r[13];

	// released pins are handed to gpio; the debug engine then sees both its inputs low
	assign pins_owned = ~cfg_r[`DHC_RELEASE_BIT];
	always_comb begin
		pin_nxt[0] = pins_owned ? 1'b0 : gpio_swclk_out_i;
		pin_nxt[1] = pins_owned ? 1'b0 : gpio_swclk_oe_i;
		pin_nxt[2] = pins_owned ? dp_swdio_out_i : gpio_swdio_out_i;
		pin_nxt[3] = pins_owned ? dp_swdio_oe_i : gpio_swdio_oe_i;
		pin_nxt[4] = pins_owned & swclk_i;
		pin_nxt[5] = pins_owned & swdio_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{dp_swdio_o, dp_swclk_o, swdio_oe_o, swdio_o, swclk_oe_o, swclk_o} <= 6'h00;
		end else begin
			{dp_swdio_o, dp_swclk_o, swdio_oe_o, swdio_o, swclk_oe_o, swclk_o} <= pin_nxt;
		end
	end

	sequence bus_take_s;
		st_r == DHC_ST_IDLE && cyc_i && stb_i;
	endsequence
	sequence bus_answer_s;
		##2 (ack_o || err_o);
	endsequence

	bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_take_s |-> bus_answer_s) else $error("access not answered two cycles after it was taken");
	id_constant_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_take_s ##0 (!we_i && sel_i == 4'hf && at_reg(adr_i, `DHC_ID_OFS)) |-> ##2 (ack_o && dat_o == ID_VALUE))
		else $error("identification read returned a wrong value");
	ctl_por_clear_a: assert property (@(posedge clk_i) por_i |=> ctl0_r == `DHC_RESET_VAL && ctl1_r == `DHC_RESET_VAL)
		else $error("control registers not cleared by power reset");
	ctl_sys_keep_a: assert property (@(posedge clk_i) disable iff (por_i) rst_i |=> ctl0_r == $past(ctl0_r))
		else $error("system reset disturbed control register zero");
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (por_i)
		(ctl0_r & ~`DHC_CTL0_MASK) == 32'h0 && (ctl1_r & ~`DHC_CTL1_MASK) == 32'h0)
		else $error("reserved control bits became set");
	soft_only_a: assert property (@(posedge clk_i) disable iff (por_i || rst_i)
		!wr_ok |=> $stable(ctl0_r) && $stable(ctl1_r)) else $error("control changed without a write");
	timer_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_halted_i && ctl0_r[`DHC_TMR13_BIT] |=> tmr13_halt_freeze_o) else $error("timer13 not frozen");
	twowire_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctl0_r[`DHC_TW1_BIT] |=> !twowire1_timeout_freeze_o) else $error("two-wire freeze without its bit");
	halt_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!core_halted_i |=> !rtc_halt_freeze_o && !window_watchdog_freeze_o && !tmr16_halt_freeze_o)
		else $error("freeze active while core runs");
	rtc_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_halted_i && ctl1_r[`DHC_RTC_BIT] |=> rtc_halt_freeze_o) else $error("rtc not frozen");
	wdg_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_halted_i && ctl0_r[`DHC_FWD_BIT] |=> free_watchdog_freeze_o) else $error("watchdog clock not stopped");
	low_power_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
		standby_i && ctl0_r[`DHC_STB_BIT] |=> internal_rc_8mhz_clock_sel_o) else $error("standby clock not kept");
	deepsleep_clk_a: assert property (@(posedge clk_i) disable iff (rst_i)
		deepsleep_i && ctl0_r[`DHC_DSLP_BIT] |=> internal_rc_8mhz_clock_sel_o) else $error("deep-sleep clock lost");
	sleep_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_clock_keep_o |-> $past(sleep_i) && $past(ctl0_r[`DHC_SLP_BIT])) else $error("bus clock kept without cause");
	standby_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(standby_i) && ctl0_r[`DHC_STB_BIT] |=> sysrst_req_o ##1 !sysrst_req_o)
		else $error("standby exit gave no one-cycle reset request");
	pin_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_r[`DHC_RELEASE_BIT] |=> swdio_oe_o == $past(gpio_swdio_oe_i) && !dp_swclk_o)
		else $error("released pins still owned by debug port");
endmodule // dhc_top

// ==== dv/dhc_cnt_model.sv ====
// Purpose: peripheral counter standing behind one freeze output of the block
// Assumes: freeze level comes straight from the block, same clock domain
// Notes:   counts every cycle it is not frozen, wraps at 8 bits
module dhc_cnt_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       freeze_i,
	output logic      [7:0] cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_o <= 8'h00;
		end else if (!freeze_i) begin
			cnt_o <= cnt_o + 8'h01;
		end
	end
endmodule // dhc_cnt_model

// ==== dv/test_debug_hold_control.sv ====
// Purpose: self-checking bench for the debug hold control block
// Assumes: classic wishbone master, every answer awaited under a bound
// Notes:   debug pins are resolved here from the block's output enables only
`include "dhc_defines.svh"
module test_debug_hold_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] id_val   = 32'h0000_1234; // arbitrary value
	localparam logic [6:0]  jep_id   = 7'h2a;         // arbitrary value
	localparam logic [11:0] part_num = 12'h5b3;       // arbitrary value
	localparam logic [31:0] base   = `DHC_BASE_ADDR;
	logic        clk_i, rst_i, por_i, cyc, stb, we, halt, slp, dslp, stby, e;
	logic [31:0] adr, wdat, q, dat_o;
	logic [3:0]  sel;
	logic        ext_clk, dp_out, dp_oe, g_co, g_coe, g_do, g_doe;
	logic        ack_o, err_o, keep_o, rc_o, srst_o, sck_o, sck_oe, sdo_o, sdo_oe, dp_sck, dp_sdo;
	logic [13:0] fz;
	logic [7:0]  cnt, c0;
	int          fails, checks_done, n;
	int          pos [14] = '{10, 11, 12, 19, 27, 16, 17, 18, 15, 16, 17, 9, 8, 10};
	logic [13:0] in_ctl1 = 14'h20e0;
	// an undriven data pin floats high through its pull-up
	wire         sck_w = sck_oe ? sck_o : ext_clk;
	wire         sdo_w = sdo_oe ? sdo_o : 1'b1;

	dhc_top #(.ID_VALUE(id_val), .JEP_ID(jep_id), .PART_NUM(part_num)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .ack_o(ack_o), .err_o(err_o), .dat_o(dat_o), .core_halted_i(halt),
		.sleep_i(slp), .deepsleep_i(dslp), .standby_i(stby), .bus_clock_keep_o(keep_o),
		.internal_rc_8mhz_clock_sel_o(rc_o), .sysrst_req_o(srst_o),
		.tmr0_halt_freeze_o(fz[13]), .tmr1_halt_freeze_o(fz[12]), .tmr2_halt_freeze_o(fz[11]),
		.tmr5_halt_freeze_o(fz[10]), .tmr13_halt_freeze_o(fz[9]), .tmr14_halt_freeze_o(fz[8]),
		.tmr15_halt_freeze_o(fz[7]), .tmr16_halt_freeze_o(fz[6]), .twowire0_timeout_freeze_o(fz[5]),
		.twowire1_timeout_freeze_o(fz[4]), .twowire2_timeout_freeze_o(fz[3]),
		.window_watchdog_freeze_o(fz[2]), .free_watchdog_freeze_o(fz[1]), .rtc_halt_freeze_o(fz[0]),
		.swclk_i(sck_w), .swclk_o(sck_o), .swclk_oe_o(sck_oe), .swdio_i(sdo_w), .swdio_o(sdo_o),
		.swdio_oe_o(sdo_oe), .dp_swclk_o(dp_sck), .dp_swdio_o(dp_sdo), .dp_swdio_out_i(dp_out),
		.dp_swdio_oe_i(dp_oe), .gpio_swclk_out_i(g_co), .gpio_swclk_oe_i(g_coe),
		.gpio_swdio_out_i(g_do), .gpio_swdio_oe_i(g_doe)
	);
	dhc_cnt_model far_cnt (.clk_i(clk_i), .rst_i(rst_i), .freeze_i(fz[13]), .cnt_o(cnt));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// entered just after a rising edge; leaves one idle cycle behind it
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		// the answer is taken at the rising edge that samples it, never earlier
		do begin
			@(posedge clk_i);
			k++;
		end while (!(ack_o === 1'b1 || err_o === 1'b1) && k < 20);
		if (k >= 20) begin
			fails++;
			wrap_up();
		end
		q = dat_o;
		e = err_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] x);
		wb(1'b0, a, 32'h0000_0000, 4'hf);
		chk(q, x);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hf);
		chk({31'h0, e}, 32'h0000_0000);
	endtask

	task automatic pw(input logic s, input logic d, input logic b, input logic [1:0] x);
		slp <= s;
		dslp <= d;
		stby <= b;
		@(posedge clk_i);
		@(negedge clk_i);
		chk({30'h0, keep_o, rc_o}, {30'h0, x});
		@(posedge clk_i);
	endtask

	task automatic pulses(input int x);
		stby <= 1'b0;
		n = 0;
		repeat (4) begin
			@(negedge clk_i);
			if (srst_o === 1'b1) n++;
		end
		chk(n, x);
		@(posedge clk_i);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		rst_i = 1; por_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; sel = 0;
		halt = 0; slp = 0; dslp = 0; stby = 0; ext_clk = 1; dp_out = 1; dp_oe = 1;
		g_co = 1; g_coe = 1; g_do = 0; g_doe = 1; fails = 0; checks_done = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		por_i <= 0;
		@(posedge clk_i);
		rd(base, id_val);
		rd(base + 32'h4, 32'h0000_0000);
		wr(base, 32'hffff_ffff);
		rd(base, id_val);
		wr(base + 32'h4, 32'hffff_ffff);
		rd(base + 32'h4, 32'h080b_9f07);
		wr(base + 32'h8, 32'hffff_ffff);
		rd(base + 32'h8, 32'h0007_0400);
		wb(1'b0, base + 32'h10, 32'h0000_0000, 4'hf);
		chk({31'h0, e}, 32'h0000_0001);
		wb(1'b1, base + 32'h4, 32'h0000_0000, 4'h1);
		chk({31'h0, e}, 32'h0000_0001);
		rd(base + 32'h4, 32'h080b_9f07);
		rd(`DHC_ROM_BASE + 32'hff0, 32'h0000_000d);
		rd(`DHC_ROM_BASE + 32'hfe4, {24'h00_0000, jep_id[3:0], part_num[11:8]});
		$display("test registers done");
		@(negedge clk_i);
		chk({18'h0, fz}, 32'h0000_0000);
		@(posedge clk_i);
		halt <= 1'b1;
		@(posedge clk_i);
		@(negedge clk_i);
		chk({18'h0, fz}, 32'h0000_3fff);
		c0 = cnt;
		repeat (3) @(negedge clk_i);
		chk({24'h0, cnt}, {24'h0, c0});
		@(posedge clk_i);
		for (int i = 0; i < 14; i++) begin
			wr(base + 32'h4, in_ctl1[i] ? 32'h0 : 32'h1 << pos[i]);
			wr(base + 32'h8, in_ctl1[i] ? 32'h1 << pos[i] : 32'h0);
			@(negedge clk_i);
			chk({18'h0, fz}, {18'h0, 14'h2000 >> i});
			@(posedge clk_i);
		end
		halt <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
		chk({18'h0, fz}, 32'h0000_0000);
		c0 = cnt;
		repeat (3) @(negedge clk_i);
		chk({24'h0, cnt}, {24'h0, c0 + 8'h03});
		@(posedge clk_i);
		$display("test freezes done");
		wr(base + 32'h4, 32'h0000_0007);
		pw(1'b1, 1'b0, 1'b0, 2'b10);
		pw(1'b0, 1'b1, 1'b0, 2'b01);
		pw(1'b0, 1'b0, 1'b1, 2'b01);
		pulses(1);
		wr(base + 32'h4, 32'h0000_0000);
		pw(1'b1, 1'b1, 1'b1, 2'b00);
		pulses(0);
		pw(1'b0, 1'b0, 1'b0, 2'b00);
		$display("test power modes done");
		wr(base + 32'h4, 32'h0000_0400);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(base + 32'h4, 32'h0000_0400);
		rst_i <= 1'b1;
		por_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		@(posedge clk_i);
		rd(base + 32'h4, 32'h0000_0000);
		rd(base + 32'h8, 32'h0000_0000);
		$display("test resets done");
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk({26'h0, sck_o, sck_oe, sdo_o, sdo_oe, dp_sck, dp_sdo}, 32'h0000_000f);
		@(posedge clk_i);
		// engine lets go of the data pin: the pull-up level must reach it
		dp_out <= 1'b0;
		dp_oe <= 1'b0;
		ext_clk <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk({26'h0, sck_o, sck_oe, sdo_o, sdo_oe, dp_sck, dp_sdo}, 32'h0000_0001);
		@(posedge clk_i);
		wr(base + 32'hc, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk({26'h0, sck_o, sck_oe, sdo_o, sdo_oe, dp_sck, dp_sdo}, 32'h0000_0034);
		$display("test pins done");
		wrap_up();
	end
endmodule // test_debug_hold_control
